// >>> hdl/bbc_pkg.sv
package bbc_pkg;

   // ==========================================================================
   // Register indices (printed offsets, not all multiples of four)
   // ==========================================================================
   localparam logic [7:0] BBC_IDX_STBY_VOLT   = 8'h3D;
   localparam logic [7:0] BBC_IDX_SLEEP_VOLT  = 8'h3E;
   localparam logic [7:0] BBC_IDX_MODE_SELECT = 8'h3F;
   localparam logic [7:0] BBC_IDX_CONFIG      = 8'h40;
   localparam logic [7:0] BBC_IDX_BOOST_CTL   = 8'h66;

   // ==========================================================================
   // Writable bit masks; all other bits are reserved and read zero
   // ==========================================================================
   localparam logic [7:0] BBC_MASK_VOLT   = 8'h1F;
   localparam logic [7:0] BBC_MASK_MODE   = 8'h2F;
   localparam logic [7:0] BBC_MASK_CONFIG = 8'h7D;
   localparam logic [7:0] BBC_MASK_BOOST  = 8'h6F;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int BBC_VOLT_MSB       = 4;
   localparam int BBC_OFF_STATE_BIT  = 5;
   localparam int BBC_SWMODE_MSB     = 3;
   localparam int BBC_RAMP_BIT       = 6;
   localparam int BBC_PHASE_LSB      = 4;
   localparam int BBC_FREQ_LSB       = 2;
   localparam int BBC_ILIM_BIT       = 0;
   localparam int BBC_BST_STBY_LSB   = 5;
   localparam int BBC_BST_NORM_LSB   = 2;
   localparam int BBC_BST_VOLT_LSB   = 0;

   // ==========================================================================
   // Boost switching modes
   // ==========================================================================
   typedef enum logic [1:0] {
      BBC_BST_OFF  = 2'b00,
      BBC_BST_PFM  = 2'b01,
      BBC_BST_AUTO = 2'b10,
      BBC_BST_APS  = 2'b11
   } bbc_bst_mode_t;

   // ==========================================================================
   // Ramp timing
   // ==========================================================================
   localparam int BBC_CLK_MHZ        = 50;
   localparam int BBC_RAMP_FAST_NS   = 2000;
   localparam int BBC_RAMP_SLOW_NS   = 4000;
   localparam int BBC_RAMP_FAST_CYC  = BBC_RAMP_FAST_NS * BBC_CLK_MHZ / 1000;
   localparam int BBC_RAMP_SLOW_CYC  = BBC_RAMP_SLOW_NS * BBC_CLK_MHZ / 1000;

   // ==========================================================================
   // AHB codes
   // ==========================================================================
   localparam logic [1:0] BBC_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] BBC_HSIZE_WORD    = 3'h2;
   localparam logic       BBC_HRESP_OKAY    = 1'h0;

endpackage

// >>> hdl/bbc_regs.sv
// Operation
// RL1 - Sleep voltage: five bits, upper bits zero
// RL2 - Standby voltage: five-bit code in 4:0
// RL3 - Mode bit 5: off or sleep after turnoff
// RL4 - Mode bits 3:0: buck switching mode selector
// RL5 - Config bit 6: ramp step every 2 or 4us
// RL6 - Config bits 5:4: phase clock, reset zero
// RL7 - Config bits 3:2: switching frequency select
// RL8 - Config bit 0: current limit select
// RL9 - Boost bits 6:5: standby switching mode
// RL10 - Boost bits 3:2: normal switching mode
// RL11 - Boost bits 1:0: output voltage code
// RL12 - Auto mode picks PFM or APS by load
// RL13 - Boost starts in auto mode when sequenced
// RL14 - Fields load defaults from OTP at reset
// RL15 - Registers readable and writable at any time; a write issued in the data phase of a previous write is dropped
// RL16 - Reserved bits ignore writes, read zero
//
// The AHB-Lite register port was left to the implementer.
module bbc_regs
   import bbc_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        otp_load,
   input  wire logic [7:0]  otp_stby_volt,
   input  wire logic [7:0]  otp_sleep_volt,
   input  wire logic [7:0]  otp_mode_select,
   input  wire logic [7:0]  otp_config,
   input  wire logic [7:0]  otp_boost_ctl,
   input  wire logic        boost_seq_enable,
   input  wire logic        boost_standby,
   input  wire logic        boost_heavy_load,
   output logic      [4:0]  buck3_standby_voltage,
   output logic      [4:0]  buck3_sleep_voltage,
   output logic             buck3_off_state_select,
   output logic      [3:0]  buck3_switch_mode,
   output logic             buck3_ramp_speed,
   output logic      [1:0]  buck3_phase_clock,
   output logic      [1:0]  buck3_switch_frequency,
   output logic             buck3_current_limit,
   output logic             buck3_ramp_tick,
   output logic      [1:0]  boost_voltage_code,
   output logic      [1:0]  boost_active_mode
);

   // ==========================================================================
   // State
   // ==========================================================================
   typedef struct packed {
      logic [7:0]  stby_volt;
      logic [7:0]  sleep_volt;
      logic [7:0]  mode_select;
      logic [7:0]  config_r;
      logic [7:0]  boost_ctl;
      logic        wr_pend;
      logic [7:0]  wr_idx;
      logic [31:0] rdata;
      logic        otp_done;
      logic        seq_en_d;
      logic [7:0]  ramp_cnt;
      logic        ramp_tick;
      logic [1:0]  bst_mode;
   } bbc_state_t;

   bbc_state_t st_ff;
   bbc_state_t nxt_st;

   logic        addr_ok;
   logic [7:0]  addr_idx;
   logic        req;
   logic [7:0]  wbyte;
   logic [7:0]  rd_val;
   logic [1:0]  sel_mode;
   logic [7:0]  ramp_limit;

   assign addr_idx = haddr[9:2];
   assign addr_ok  = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
   assign req      = hsel && hready && htrans[1];
   assign wbyte    = hwdata[7:0];

   // ==========================================================================
   // Read mux
   // ==========================================================================
   always_comb begin
      rd_val = 8'h00;
      if (addr_ok) begin
         // RL16 reserved bits zero
         unique case (addr_idx)
            BBC_IDX_STBY_VOLT:   rd_val = st_ff.stby_volt & BBC_MASK_VOLT;
            BBC_IDX_SLEEP_VOLT:  rd_val = st_ff.sleep_volt & BBC_MASK_VOLT;
            BBC_IDX_MODE_SELECT: rd_val = st_ff.mode_select & BBC_MASK_MODE;
            BBC_IDX_CONFIG:      rd_val = st_ff.config_r & BBC_MASK_CONFIG;
            BBC_IDX_BOOST_CTL:   rd_val = st_ff.boost_ctl & BBC_MASK_BOOST;
            default:             rd_val = 8'h00;
         endcase
      end
   end

   // ==========================================================================
   // Next state
   // ==========================================================================
   always_comb begin
      nxt_st = st_ff;
      // RL15 always accessible
      nxt_st.wr_pend = req && hwrite && addr_ok;
      if (req) begin
         nxt_st.wr_idx = addr_idx;
         nxt_st.rdata  = hwrite ? 32'h0 : {24'h0, rd_val};
      end

      // RL16 masked write
      if (st_ff.wr_pend) begin
         unique case (st_ff.wr_idx)
            // RL2 standby voltage
            BBC_IDX_STBY_VOLT:   nxt_st.stby_volt = wbyte & BBC_MASK_VOLT;
            // RL1 sleep voltage
            BBC_IDX_SLEEP_VOLT:  nxt_st.sleep_volt = wbyte & BBC_MASK_VOLT;
            // RL3 RL4 mode select
            BBC_IDX_MODE_SELECT: nxt_st.mode_select = wbyte & BBC_MASK_MODE;
            // RL6 RL7 RL8 config
            BBC_IDX_CONFIG:      nxt_st.config_r = wbyte & BBC_MASK_CONFIG;
            // RL9 RL10 RL11 boost control
            BBC_IDX_BOOST_CTL:   nxt_st.boost_ctl = wbyte & BBC_MASK_BOOST;
            default:             nxt_st.wr_pend = 1'b0;
         endcase
         nxt_st.wr_pend = 1'b0;
      end

      // RL14 load OTP once
      if (otp_load && !st_ff.otp_done) begin
         nxt_st.otp_done    = 1'b1;
         nxt_st.stby_volt   = otp_stby_volt & BBC_MASK_VOLT;
         nxt_st.sleep_volt  = otp_sleep_volt & BBC_MASK_VOLT;
         nxt_st.mode_select = otp_mode_select & BBC_MASK_MODE;
         nxt_st.config_r    = otp_config & BBC_MASK_CONFIG & 8'hCF;
         nxt_st.boost_ctl   = otp_boost_ctl & BBC_MASK_BOOST;
      end

      // RL13 auto on sequence
      nxt_st.seq_en_d = boost_seq_enable;
      if (boost_seq_enable && !st_ff.seq_en_d) begin
         nxt_st.boost_ctl[BBC_BST_NORM_LSB +: 2] = BBC_BST_AUTO;
      end

      // RL12 auto picks by load
      sel_mode = boost_standby ? nxt_st.boost_ctl[BBC_BST_STBY_LSB +: 2]
                               : nxt_st.boost_ctl[BBC_BST_NORM_LSB +: 2];
      if (!boost_seq_enable) begin
         nxt_st.bst_mode = BBC_BST_OFF;
      end else if (sel_mode == BBC_BST_AUTO) begin
         nxt_st.bst_mode = boost_heavy_load ? BBC_BST_APS : BBC_BST_PFM;
      end else begin
         nxt_st.bst_mode = sel_mode;
      end

      // RL5 ramp step pacing
      ramp_limit = st_ff.config_r[BBC_RAMP_BIT] ? 8'(BBC_RAMP_SLOW_CYC - 1)
                                                : 8'(BBC_RAMP_FAST_CYC - 1);
      nxt_st.ramp_tick = 1'b0;
      if (st_ff.ramp_cnt >= ramp_limit) begin
         nxt_st.ramp_cnt  = 8'h00;
         nxt_st.ramp_tick = 1'b1;
      end else begin
         nxt_st.ramp_cnt = st_ff.ramp_cnt + 8'h01;
      end
   end

   // ==========================================================================
   // Registers
   // ==========================================================================
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   assign hrdata                 = st_ff.rdata;
   assign hreadyout              = 1'b1;
   assign hresp                  = BBC_HRESP_OKAY;
   assign buck3_standby_voltage  = st_ff.stby_volt[BBC_VOLT_MSB:0];
   assign buck3_sleep_voltage    = st_ff.sleep_volt[BBC_VOLT_MSB:0];
   assign buck3_off_state_select = st_ff.mode_select[BBC_OFF_STATE_BIT];
   assign buck3_switch_mode      = st_ff.mode_select[BBC_SWMODE_MSB:0];
   assign buck3_ramp_speed       = st_ff.config_r[BBC_RAMP_BIT];
   assign buck3_phase_clock      = st_ff.config_r[BBC_PHASE_LSB +: 2];
   assign buck3_switch_frequency = st_ff.config_r[BBC_FREQ_LSB +: 2];
   assign buck3_current_limit    = st_ff.config_r[BBC_ILIM_BIT];
   assign buck3_ramp_tick        = st_ff.ramp_tick;
   assign boost_voltage_code     = st_ff.boost_ctl[BBC_BST_VOLT_LSB +: 2];
   assign boost_active_mode      = st_ff.bst_mode;

   // ==========================================================================
   // Checks
   // ==========================================================================
   chk_sleep_reserved: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
      st_ff.sleep_volt[7:5] == 3'h0) else $error("sleep voltage reserved bits set");

   chk_stby_write: assert property (@(posedge hclk) disable iff (!hresetn) // RL2
      (st_ff.wr_pend && st_ff.wr_idx == BBC_IDX_STBY_VOLT && !(otp_load && !st_ff.otp_done))
      |=> buck3_standby_voltage == $past(hwdata[4:0]))
      else $error("standby voltage write lost");

   chk_off_state: assert property (@(posedge hclk) disable iff (!hresetn) // RL3
      buck3_off_state_select == st_ff.mode_select[5]) else $error("off state mismatch");

   chk_mode_reserved: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
      (st_ff.mode_select & ~BBC_MASK_MODE) == 8'h00) else $error("mode reserved bits set");

   chk_ramp_period: assert property (@(posedge hclk) disable iff (!hresetn) // RL5
      (buck3_ramp_tick && !buck3_ramp_speed && $stable(st_ff.config_r)) |=>
      (!buck3_ramp_tick [*8]))
      else $error("ramp ticks too close");

   chk_phase_otp: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
      (otp_load && !st_ff.otp_done) |=> buck3_phase_clock == 2'h0)
      else $error("phase clock not cleared on load");

   chk_cfg_reserved: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
      st_ff.config_r[7] == 1'b0 && st_ff.config_r[1] == 1'b0)
      else $error("config reserved bits set");

   chk_boost_auto: assert property (@(posedge hclk) disable iff (!hresetn) // RL12
      (boost_seq_enable && !boost_standby && st_ff.boost_ctl[3:2] == BBC_BST_AUTO
       && $stable(st_ff.boost_ctl) && !st_ff.wr_pend) |=> boost_active_mode == ($past(boost_heavy_load)
       ? BBC_BST_APS : BBC_BST_PFM)) else $error("auto mode choice wrong");

   chk_boost_start: assert property (@(posedge hclk) disable iff (!hresetn) // RL13
      $rose(boost_seq_enable) |=> st_ff.boost_ctl[3:2] == BBC_BST_AUTO)
      else $error("boost not auto at enable");

   chk_read_ready: assert property (@(posedge hclk) disable iff (!hresetn) // RL15
      hreadyout && hresp == BBC_HRESP_OKAY) else $error("bus not ready");

   // ==========================================================================
   // Write landing, mode selection, ramp pacing and reserved bit checks
   // ==========================================================================
   logic otp_hit;
   assign otp_hit = otp_load && !st_ff.otp_done;

   chk_sleep_write: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
      (st_ff.wr_pend && st_ff.wr_idx == BBC_IDX_SLEEP_VOLT && !otp_hit)
      |=> buck3_sleep_voltage == $past(hwdata[4:0]))
      else $error("sleep voltage write lost");

   chk_stby_reserved: assert property (@(posedge hclk) disable iff (!hresetn) // RL2
      st_ff.stby_volt[7:5] == 3'h0) else $error("standby voltage reserved bits set");

   chk_off_write: assert property (@(posedge hclk) disable iff (!hresetn) // RL3
      (st_ff.wr_pend && st_ff.wr_idx == BBC_IDX_MODE_SELECT && !otp_hit)
      |=> buck3_off_state_select == $past(hwdata[5]))
      else $error("off state write lost");

   chk_mode_write: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
      (st_ff.wr_pend && st_ff.wr_idx == BBC_IDX_MODE_SELECT && !otp_hit)
      |=> buck3_switch_mode == $past(hwdata[3:0]))
      else $error("switch mode write lost");

   chk_ramp_write: assert property (@(posedge hclk) disable iff (!hresetn) // RL5
      (st_ff.wr_pend && st_ff.wr_idx == BBC_IDX_CONFIG && !otp_hit)
      |=> buck3_ramp_speed == $past(hwdata[6]))
      else $error("ramp speed write lost");

   chk_ramp_bound: assert property (@(posedge hclk) disable iff (!hresetn) // RL5
      st_ff.ramp_cnt <= 8'(BBC_RAMP_SLOW_CYC - 1)) else $error("ramp counter overrun");

   chk_ramp_pulse: assert property (@(posedge hclk) disable iff (!hresetn) // RL5
      buck3_ramp_tick |=> !buck3_ramp_tick)
      else $error("ramp tick longer than one cycle");

   chk_phase_write: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
      (st_ff.wr_pend && st_ff.wr_idx == BBC_IDX_CONFIG && !otp_hit)
      |=> buck3_phase_clock == $past(hwdata[5:4]))
      else $error("phase clock write lost");

   chk_freq_write: assert property (@(posedge hclk) disable iff (!hresetn) // RL7
      (st_ff.wr_pend && st_ff.wr_idx == BBC_IDX_CONFIG && !otp_hit)
      |=> buck3_switch_frequency == $past(hwdata[3:2]))
      else $error("switch frequency write lost");

   chk_ilim_write: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
      (st_ff.wr_pend && st_ff.wr_idx == BBC_IDX_CONFIG && !otp_hit)
      |=> buck3_current_limit == $past(hwdata[0]))
      else $error("current limit write lost");

   chk_bst_stby_write: assert property (@(posedge hclk) disable iff (!hresetn) // RL9
      (st_ff.wr_pend && st_ff.wr_idx == BBC_IDX_BOOST_CTL && !otp_hit)
      |=> st_ff.boost_ctl[6:5] == $past(hwdata[6:5]))
      else $error("boost standby mode write lost");

   chk_bst_stby_sel: assert property (@(posedge hclk) disable iff (!hresetn) // RL9
      (boost_seq_enable && boost_standby && st_ff.boost_ctl[6:5] != BBC_BST_AUTO
       && !st_ff.wr_pend && !otp_hit)
      |=> boost_active_mode == $past(st_ff.boost_ctl[6:5]))
      else $error("boost standby mode not applied");

   chk_bst_norm_write: assert property (@(posedge hclk) disable iff (!hresetn) // RL10
      (st_ff.wr_pend && st_ff.wr_idx == BBC_IDX_BOOST_CTL && !otp_hit
       && !$rose(boost_seq_enable))
      |=> st_ff.boost_ctl[3:2] == $past(hwdata[3:2]))
      else $error("boost normal mode write lost");

   chk_bst_norm_sel: assert property (@(posedge hclk) disable iff (!hresetn) // RL10
      (boost_seq_enable && !boost_standby && st_ff.boost_ctl[3:2] != BBC_BST_AUTO
       && !st_ff.wr_pend && !otp_hit && !$rose(boost_seq_enable))
      |=> boost_active_mode == $past(st_ff.boost_ctl[3:2]))
      else $error("boost normal mode not applied");

   chk_bst_volt_write: assert property (@(posedge hclk) disable iff (!hresetn) // RL11
      (st_ff.wr_pend && st_ff.wr_idx == BBC_IDX_BOOST_CTL && !otp_hit)
      |=> boost_voltage_code == $past(hwdata[1:0]))
      else $error("boost voltage write lost");

   chk_bst_off: assert property (@(posedge hclk) disable iff (!hresetn) // RL12
      !boost_seq_enable |=> boost_active_mode == BBC_BST_OFF)
      else $error("boost active while not enabled");

   chk_write_taken: assert property (@(posedge hclk) disable iff (!hresetn) // RL15
      (hsel && hready && htrans[1] && hwrite && addr_ok) |=> st_ff.wr_pend)
      else $error("write request not taken");

   chk_bst_reserved: assert property (@(posedge hclk) disable iff (!hresetn) // RL16
      (st_ff.boost_ctl & ~BBC_MASK_BOOST) == 8'h00) else $error("boost reserved bits set");

   chk_rdata_upper: assert property (@(posedge hclk) disable iff (!hresetn) // RL16
      hrdata[31:8] == 24'h0) else $error("read data upper bits set");

endmodule

// >>> dv/bbc_regs_tb_top.sv
module bbc_regs_tb_top import bbc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic        hclk, hresetn, hsel, hwrite, hready, otp_load, hreadyout, hresp;
   logic        boost_seq_enable, boost_standby, boost_heavy_load, buck3_ramp_tick;
   logic        buck3_off_state_select, buck3_ramp_speed, buck3_current_limit;
   logic [31:0] haddr, hwdata, hrdata;
   logic [2:0]  hsize;
   logic [1:0]  htrans, buck3_phase_clock, buck3_switch_frequency;
   logic [1:0]  boost_voltage_code, boost_active_mode;
   logic [4:0]  buck3_standby_voltage, buck3_sleep_voltage;
   logic [3:0]  buck3_switch_mode;
   logic [7:0]  otp_stby_volt, otp_sleep_volt, otp_mode_select, otp_config, otp_boost_ctl;
   logic [7:0]  mdl [5];
   logic [7:0]  idx_tab [5];
   logic [15:0] seed;
   int          fails, cmp_count;

   bbc_regs dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hrdata, .hreadyout, .hresp, .otp_load, .otp_stby_volt, .otp_sleep_volt,
      .otp_mode_select, .otp_config, .otp_boost_ctl, .boost_seq_enable, .boost_standby,
      .boost_heavy_load, .buck3_standby_voltage, .buck3_sleep_voltage,
      .buck3_off_state_select, .buck3_switch_mode, .buck3_ramp_speed, .buck3_phase_clock,
      .buck3_switch_frequency, .buck3_current_limit, .buck3_ramp_tick,
      .boost_voltage_code, .boost_active_mode);

   always #10 hclk = ~hclk;

   // ==========================================================================
   // Expectation helpers
   // ==========================================================================
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [7:0] mask_of(input logic [7:0] idx);
      case (idx)
         BBC_IDX_STBY_VOLT, BBC_IDX_SLEEP_VOLT: return BBC_MASK_VOLT;
         BBC_IDX_MODE_SELECT: return BBC_MASK_MODE;
         BBC_IDX_CONFIG: return BBC_MASK_CONFIG;
         BBC_IDX_BOOST_CTL: return BBC_MASK_BOOST;
         default: return 8'h00;
      endcase
   endfunction

   function automatic logic [1:0] act_of(input logic [7:0] b, input logic en, st, hv);
      logic [1:0] m;
      m = st ? b[6:5] : b[3:2];
      if (!en) return BBC_BST_OFF;
      if (m == BBC_BST_AUTO) return hv ? BBC_BST_APS : BBC_BST_PFM;
      return m;
   endfunction

   // ==========================================================================
   // Checks, verdict and bus master
   // ==========================================================================
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rnd(output logic [15:0] v);
      seed = lfsr_next(seed);
      v = seed;
   endtask

   // Samples just before the edge so the answer is taken at that edge
   task automatic wait_rdy(output logic [31:0] rd);
      int n;
      for (n = 0; n < 50; n++) begin
         @(negedge hclk);
         rd = hrdata;
         if (hreadyout === 1'b1) break;
      end
      if (n == 50) begin
         fails++;
         print_verdict();
      end
      @(posedge hclk);
   endtask

   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= BBC_HTRANS_NONSEQ;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= wr;
      wait_rdy(rd);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy(rd);
   endtask

   task automatic wr(input int i, input logic [31:0] wd);
      logic [31:0] rd;
      bus(1'b1, idx_tab[i], wd, rd);
      mdl[i] = wd[7:0] & mask_of(idx_tab[i]);
   endtask

   task automatic rd_chk(input int i);
      logic [31:0] rd;
      bus(1'b0, idx_tab[i], 32'h0, rd);
      chk(rd, {24'h0, mdl[i]});
   endtask

   task automatic chk_out();
      repeat (3) @(negedge hclk);
      chk({9'h0, buck3_standby_voltage, buck3_sleep_voltage, buck3_off_state_select,
           buck3_switch_mode, buck3_ramp_speed, buck3_phase_clock, buck3_switch_frequency,
           buck3_current_limit, boost_voltage_code},
          {9'h0, mdl[0][4:0], mdl[1][4:0], mdl[2][5], mdl[2][3:0], mdl[3][6], mdl[3][5:4],
           mdl[3][3:2], mdl[3][0], mdl[4][1:0]});
      chk({30'h0, boost_active_mode}, {30'h0, act_of(mdl[4], boost_seq_enable,
           boost_standby, boost_heavy_load)});
      @(posedge hclk);
   endtask

   task automatic ramp(input int expc);
      int k;
      int gap;
      for (k = 0; k < 600 && buck3_ramp_tick !== 1'b1; k++) @(negedge hclk);
      gap = 0;
      do begin
         @(negedge hclk);
         gap++;
      end while (buck3_ramp_tick !== 1'b1 && gap < 600);
      chk(32'(gap), 32'(expc));
      @(posedge hclk);
   endtask

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      logic [15:0] r;
      logic [15:0] r2;
      logic [31:0] rd;
      int          i;
      int          k;
      hclk = 1'b0;
      hresetn = 1'b0;
      {hsel, hwrite, otp_load, boost_seq_enable, boost_standby, boost_heavy_load} = 6'h00;
      {haddr, hwdata, htrans} = 66'h0;
      hsize = BBC_HSIZE_WORD;
      hready = 1'b1;
      {otp_stby_volt, otp_sleep_volt, otp_mode_select, otp_config, otp_boost_ctl} = 40'h0;
      seed = 16'h002C;
      idx_tab = '{BBC_IDX_STBY_VOLT, BBC_IDX_SLEEP_VOLT, BBC_IDX_MODE_SELECT,
                  BBC_IDX_CONFIG, BBC_IDX_BOOST_CTL};
      mdl = '{default: 8'h00};
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      for (i = 0; i < 5; i++) rd_chk(i);
      for (i = 0; i < 5; i++) begin
         rnd(r);
         mdl[i] = r[7:0];
      end
      mdl[3] = mdl[3] | 8'h30;
      {otp_stby_volt, otp_sleep_volt, otp_mode_select, otp_config, otp_boost_ctl} <=
         {mdl[0], mdl[1], mdl[2], mdl[3], mdl[4]};
      otp_load <= 1'b1;
      for (i = 0; i < 5; i++) mdl[i] = mdl[i] & mask_of(idx_tab[i]);
      mdl[3][5:4] = 2'h0;
      @(posedge hclk);
      otp_load <= 1'b0;
      chk_out();
      for (i = 0; i < 5; i++) rd_chk(i);
      for (k = 0; k < 40; k++) begin
         rnd(r);
         rnd(r2);
         boost_standby <= r[5];
         boost_heavy_load <= r[6];
         otp_load <= r[7];
         wr(r % 5, {r2, r});
         rd_chk(r2 % 5);
         chk_out();
      end
      otp_load <= 1'b0;
      bus(1'b1, 8'h41, 32'hFFFF_FFFF, rd);
      bus(1'b0, 8'h41, 32'h0, rd);
      chk(rd, 32'h0);
      bus(1'b0, 8'h3C, 32'h0, rd);
      chk(rd, 32'h0);
      for (i = 0; i < 5; i++) rd_chk(i);
      wr(4, 32'h0000_0000);
      boost_seq_enable <= 1'b1;
      mdl[4][3:2] = BBC_BST_AUTO;
      chk_out();
      rd_chk(4);
      for (k = 0; k < 16; k++) begin
         boost_standby <= k[1];
         boost_heavy_load <= k[0];
         wr(4, {25'h0, k[3:2], 1'b1, ~k[3:2], k[1:0]});
         chk_out();
      end
      wr(3, 32'h0000_0000);
      ramp(BBC_RAMP_FAST_CYC);
      wr(3, 32'h0000_0040);
      ramp(BBC_RAMP_SLOW_CYC);
      print_verdict();
   end
endmodule
